// ### src/ofpc_ctrl.sv
// flash sequencer: page programming, block and chip erase, status polling,
// software block protection, read protect and boot mode from the strap.
// assumes the cpu issues at most one request per cycle on clk; the strap
// is an asynchronous pin and is synchronised before use.
`timescale 1ns/10ps
`include "ofpc_defines.svh"

module ofpc_ctrl #(
  parameter int unsigned PROG_CYC   = `OFPC_PROG_CYC,
  parameter int unsigned ERASE_CYC  = `OFPC_ERASE_CYC,
  parameter bit          SMALL_PAGE = 1'b0
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire ofpc_pkg::ofpc_req_t      req,
  input  wire logic                     read_protect,
  input  wire logic                     ext_tool_read,
  input  wire logic                     strap_port_bit_zero,
  output      ofpc_pkg::ofpc_rsp_t      rsp,
  output      logic                     busy,
  output      logic                     single_chip,
  output      logic [`OFPC_DATA_W-1:0]  fetch_base,
  output      logic [`OFPC_BLOCKS-1:0]  protect_state
);

  localparam int unsigned PAGE_WORDS = SMALL_PAGE ? `OFPC_PAGE_SMALL : `OFPC_PAGE_LARGE;
  localparam int unsigned PAGE_AW    = $clog2(`OFPC_PAGE_LARGE);
  localparam int unsigned BLK_AW     = $clog2(`OFPC_BLOCKS);
  localparam int unsigned CNT_W      = $clog2(ERASE_CYC + 1);

  typedef enum logic [1:0] {OFPC_IDLE, OFPC_PROG, OFPC_ERASE} ofpc_state_t;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [`OFPC_DATA_W-1:0] mem      [`OFPC_WORDS];
  logic [`OFPC_DATA_W-1:0] page_buf [`OFPC_PAGE_LARGE];
  logic [`OFPC_PAGE_LARGE-1:0] page_loaded;
  logic [`OFPC_ADDR_W-1:0] page_addr;
  logic [BLK_AW-1:0]       op_block;
  logic                    op_chip;
  logic [CNT_W-1:0]        timer;
  logic                    toggle;
  logic                    done;
  ofpc_state_t             state;
  logic [2:0]              strap_sync;
  logic                    boot_pending;
  logic [`OFPC_DATA_W-1:0] status_word;

  wire [BLK_AW-1:0]  req_block = req.addr[`OFPC_BLOCK_SHIFT +: BLK_AW];
  wire [PAGE_AW-1:0] req_off   = req.addr[PAGE_AW-1:0] & PAGE_AW'(PAGE_WORDS - 1);
  wire               req_prot  = protect_state[req_block];
  wire               start_prog  = (state == OFPC_IDLE) && (req.cmd == ofpc_pkg::OFPC_CMD_PROG)
                                   && !req_prot;
  wire               start_blk   = (state == OFPC_IDLE)
                                   && (req.cmd == ofpc_pkg::OFPC_CMD_BLK_ERASE) && !req_prot;
  wire               start_chip  = (state == OFPC_IDLE)
                                   && (req.cmd == ofpc_pkg::OFPC_CMD_CHIP_ERASE)
                                   && (protect_state == '0);

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  // loads and protection changes are taken only while the sequencer is
  // idle; one that arrives during an operation is dropped without notice,
  // so software must poll for the end before it issues the next one
  wire               is_idle      = (state == OFPC_IDLE);
  wire               take_load    = is_idle && (req.cmd == ofpc_pkg::OFPC_CMD_LOAD);
  wire               take_protect = is_idle && (req.cmd == ofpc_pkg::OFPC_CMD_PROTECT);
  wire               take_unprot  = is_idle && (req.cmd == ofpc_pkg::OFPC_CMD_UNPROTECT);
  wire               take_read    = (req.cmd == ofpc_pkg::OFPC_CMD_READ);
  // last count of an operation: the array is updated on this edge
  wire               prog_commit  = (state == OFPC_PROG) && (timer == '0);
  wire               erase_commit = (state == OFPC_ERASE) && (timer == '0);

  // ------------------------------------------------------------
  // operation sequencer
  // ------------------------------------------------------------
  // no suspend command exists: once started, an erase runs to its end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= OFPC_IDLE;
      timer    <= '0;
      op_block <= '0;
      op_chip  <= 1'b0;
      page_addr <= '0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        OFPC_IDLE: begin
          if (start_prog) begin
            state     <= OFPC_PROG;
            timer     <= CNT_W'(PROG_CYC - 1);
            page_addr <= req.addr & ~`OFPC_ADDR_W'(PAGE_WORDS - 1);
          end else if (start_blk || start_chip) begin
            state    <= OFPC_ERASE;
            timer    <= CNT_W'(ERASE_CYC - 1);
            op_block <= req_block;
            op_chip  <= start_chip;
          end
        end
        OFPC_PROG, OFPC_ERASE: begin
          if (timer == '0) begin
            state <= OFPC_IDLE;
            done  <= 1'b1;
          end else begin
            timer <= timer - CNT_W'(1);
          end
        end
        default: state <= OFPC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // page buffer and array update
  // ------------------------------------------------------------
  // loads are taken only while idle; the page is committed when the
  // program time expires, so the whole page costs one program time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page_loaded <= '0;
    end else if (take_load) begin
      page_loaded[req_off] <= 1'b1;
    end else if (prog_commit) begin
      // cleared with the commit so the next page starts with no words
      page_loaded <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (take_load) begin
      page_buf[req_off] <= req.wdata;
    end
  end

  // only the addressed page or block changes, or every block on a chip erase; other blocks untouched
  generate
    for (genvar w = 0; w < `OFPC_WORDS; w++) begin : g_word
      localparam logic [BLK_AW-1:0]  W_BLK = BLK_AW'(w >> `OFPC_BLOCK_SHIFT);
      localparam logic [PAGE_AW-1:0] W_OFF = PAGE_AW'(w % PAGE_WORDS);
      always_ff @(posedge clk) begin
        if (erase_commit && (op_chip || op_block == W_BLK)) begin
          mem[w] <= `OFPC_ERASED;
        end else if (prog_commit && page_loaded[W_OFF]
                     && page_addr == (`OFPC_ADDR_W'(w) & ~`OFPC_ADDR_W'(PAGE_WORDS - 1))) begin
          mem[w] <= mem[w] & page_buf[W_OFF];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // software protection
  // ------------------------------------------------------------
  // protection moves only by command or reset; there is no high-voltage pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      protect_state <= '0;
    end else if (take_protect) begin
      protect_state[req_block] <= 1'b1;
    end else if (take_unprot) begin
      protect_state <= '0;
    end
  end

  // ------------------------------------------------------------
  // read path and status
  // ------------------------------------------------------------
  // status word seen by reads during an operation: poll bit low until the
  // end, toggle bit inverted on every read so a polling loop sees motion
  always_comb begin
    status_word                   = '0;
    status_word[`OFPC_TOGGLE_BIT] = ~toggle;
    status_word[`OFPC_POLL_BIT]   = 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp    <= '0;
      toggle <= 1'b0;
    end else begin
      rsp.valid     <= 1'b0;
      rsp.is_status <= 1'b0;
      if (take_read) begin
        rsp.valid <= 1'b1;
        if (!is_idle) begin
          toggle        <= ~toggle;
          rsp.is_status <= 1'b1;
          rsp.rdata     <= status_word;
        end else if (read_protect && ext_tool_read) begin
          rsp.rdata <= '0;
        end else begin
          rsp.rdata <= mem[req.addr[$clog2(`OFPC_WORDS)-1:0]];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != OFPC_IDLE) && !done;
    end
  end

  // ------------------------------------------------------------
  // boot mode strap
  // ------------------------------------------------------------
  // the synchroniser has no reset on purpose: it keeps sampling the pin
  // while reset is held, so the level present at release already sits in
  // the last two stages. a reset of fewer than three clocks leaves them
  // unknown, and the mode is then taken from the first agreed sample.
  // the mode is held until the next reset; later strap changes are ignored
  always_ff @(posedge clk) begin
    strap_sync <= {strap_sync[1:0], strap_port_bit_zero};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_pending <= 1'b1;
      single_chip  <= 1'b0;
      fetch_base   <= `OFPC_ROM_BASE;
    end else if (boot_pending && (strap_sync[1] == strap_sync[2])) begin
      boot_pending <= 1'b0;
      single_chip  <= strap_sync[2];
      fetch_base   <= strap_sync[2] ? `OFPC_FLASH_BASE : `OFPC_ROM_BASE;
    end
  end

endmodule : ofpc_ctrl

// ### src/ofpc_defines.svh
// constants for the on-chip flash program/erase controller
// assumes a 10 MHz system clock and a simple cpu-side request port
`ifndef OFPC_DEFINES_SVH
`define OFPC_DEFINES_SVH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define OFPC_DATA_W        32
`define OFPC_ADDR_W        17
`define OFPC_WORDS         4096
`define OFPC_BLOCKS        4
`define OFPC_BLOCK_SHIFT   10
`define OFPC_PAGE_LARGE    128
`define OFPC_PAGE_SMALL    64

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define OFPC_CLK_HZ        10000000
`define OFPC_PROG_NS       1250000
`define OFPC_ERASE_NS      100000000
`define OFPC_PROG_CYC      ((`OFPC_PROG_NS / 1000) * (`OFPC_CLK_HZ / 1000000))
`define OFPC_ERASE_CYC     ((`OFPC_ERASE_NS / 1000) * (`OFPC_CLK_HZ / 1000000))

// ------------------------------------------------------------
// status word, erased value and boot fetch bases
// ------------------------------------------------------------
`define OFPC_ERASED        32'hFFFFFFFF
`define OFPC_POLL_BIT      7
`define OFPC_TOGGLE_BIT    6
`define OFPC_ROM_BASE      32'h00000000
`define OFPC_FLASH_BASE    32'h00010000

`endif

// ### src/ofpc_pkg.sv
// types for the on-chip flash program/erase controller
// shared by the controller and whoever drives its command port
`include "ofpc_defines.svh"

package ofpc_pkg;

  typedef enum logic [2:0] {
    OFPC_CMD_NONE,
    OFPC_CMD_READ,
    OFPC_CMD_LOAD,
    OFPC_CMD_PROG,
    OFPC_CMD_BLK_ERASE,
    OFPC_CMD_CHIP_ERASE,
    OFPC_CMD_PROTECT,
    OFPC_CMD_UNPROTECT
  } ofpc_cmd_t;

  typedef struct packed {
    ofpc_cmd_t                 cmd;
    logic [`OFPC_ADDR_W-1:0]   addr;
    logic [`OFPC_DATA_W-1:0]   wdata;
  } ofpc_req_t;

  typedef struct packed {
    logic                      valid;
    logic                      is_status;
    logic [`OFPC_DATA_W-1:0]   rdata;
  } ofpc_rsp_t;

endpackage : ofpc_pkg

// ### testbench/ofpc_ctrl_asserts.sv
// checker for the flash sequencer, bound from the bench top
// assumes only the controller ports are visible
`timescale 1ns/10ps
`include "ofpc_defines.svh"
module ofpc_ctrl_asserts #(
  parameter int unsigned PROG_CYC  = 20,
  parameter int unsigned ERASE_CYC = 50
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire ofpc_pkg::ofpc_req_t     req,
  input wire logic                    read_protect,
  input wire logic                    ext_tool_read,
  input wire logic                    strap_port_bit_zero,
  input wire ofpc_pkg::ofpc_rsp_t     rsp,
  input wire logic                    busy,
  input wire logic                    single_chip,
  input wire logic [`OFPC_DATA_W-1:0] fetch_base,
  input wire logic [`OFPC_BLOCKS-1:0] protect_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int unsigned busy_len;
  logic        have_prev;
  logic        last_tog;
  wire logic   idle_ok = !busy
                         && !protect_state[req.addr[`OFPC_BLOCK_SHIFT+:$clog2(`OFPC_BLOCKS)]];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busy_len <= 0;
    else if (busy) busy_len <= busy_len + 1;
    else busy_len <= 0;
  end
  // only consecutive status reads of one operation are compared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      have_prev <= 1'b0;
      last_tog  <= 1'b0;
    end else if (!busy) begin
      have_prev <= 1'b0;
    end else if (rsp.valid && rsp.is_status) begin
      have_prev <= 1'b1;
      last_tog  <= rsp.rdata[`OFPC_TOGGLE_BIT];
    end
  end
  sequence s_answer;
    ##[1:2] rsp.valid;
  endsequence
  chk_read_answer: assert property (req.cmd == ofpc_pkg::OFPC_CMD_READ |-> s_answer)
    else $error("read got no answer");
  chk_busy_hides: assert property (busy && rsp.valid |-> rsp.is_status)
    else $error("stored data returned while busy");
  chk_poll_bit: assert property (busy && rsp.valid |-> !rsp.rdata[`OFPC_POLL_BIT])
    else $error("poll bit set while busy");
  chk_toggle_flip: assert property (busy && rsp.valid && rsp.is_status && have_prev
    |-> rsp.rdata[`OFPC_TOGGLE_BIT] != last_tog) else $error("toggle bit did not flip");
  chk_op_length: assert property ($fell(busy) |->
    (busy_len + 2 >= PROG_CYC && busy_len <= PROG_CYC + 2) ||
    (busy_len + 2 >= ERASE_CYC && busy_len <= ERASE_CYC + 2)) else $error("bad busy length");
  chk_prog_start: assert property (req.cmd == ofpc_pkg::OFPC_CMD_PROG && idle_ok
    |-> ##[1:2] busy) else $error("program not started");
  chk_protect_block: assert property (!busy && !idle_ok &&
    req.cmd inside {ofpc_pkg::OFPC_CMD_PROG, ofpc_pkg::OFPC_CMD_BLK_ERASE} |=> !busy)
    else $error("protected block was changed");
  chk_chip_refuse: assert property (req.cmd == ofpc_pkg::OFPC_CMD_CHIP_ERASE && !busy
    && (|protect_state) |=> !busy) else $error("chip erase ran while protected");
  chk_read_guard: assert property (req.cmd == ofpc_pkg::OFPC_CMD_READ && !busy &&
    read_protect && ext_tool_read |-> ##[1:2] (rsp.valid && rsp.rdata == '0))
    else $error("external read not blocked");
  chk_mode_flash: assert property ($fell(rst) && strap_port_bit_zero |-> ##[1:4]
    (single_chip && fetch_base == `OFPC_FLASH_BASE)) else $error("single-chip mode not taken");
  chk_mode_rom: assert property ($fell(rst) && !strap_port_bit_zero |-> ##2
    (!single_chip && fetch_base == `OFPC_ROM_BASE)) else $error("serial-boot mode not taken");
endmodule : ofpc_ctrl_asserts

// ### testbench/ofpc_cpu_model.sv
// cpu side model: one request at a time on the controller port
// assumes the caller starts just after a rising clk edge
`timescale 1ns/10ps
module ofpc_cpu_model (
  input  wire logic                clk,
  input  wire ofpc_pkg::ofpc_rsp_t rsp,
  output      ofpc_pkg::ofpc_req_t req
);
  initial req = '0;
  // request held through its taking edge; answer may lag one more cycle
  task automatic send(input ofpc_pkg::ofpc_cmd_t cmd, input logic [16:0] addr,
                      input logic [31:0] wdata, output ofpc_pkg::ofpc_rsp_t got);
    @(posedge clk);
    #1;
    req = '{cmd, addr, wdata};
    @(posedge clk);
    #1;
    req = '0;
    got = rsp;
    if (!got.valid) begin
      @(posedge clk);
      #1;
      got = rsp;
    end
  endtask : send
endmodule : ofpc_cpu_model

// ### testbench/tb_onchip_flash_program_control.sv
// self-checking bench for the flash sequencer
// assumes the cpu model and the checker are compiled first
`timescale 1ns/10ps
`include "ofpc_defines.svh"
module tb_onchip_flash_program_control;
  localparam int unsigned PROG_CYC  = 20;
  localparam int unsigned ERASE_CYC = 50;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    read_protect = 1'b0;
  logic                    ext_tool_read = 1'b0;
  logic                    strap_port_bit_zero = 1'b1;
  ofpc_pkg::ofpc_req_t     req;
  ofpc_pkg::ofpc_rsp_t     rsp;
  ofpc_pkg::ofpc_rsp_t     got;
  logic                    busy;
  logic                    single_chip;
  logic [`OFPC_DATA_W-1:0] fetch_base;
  logic [`OFPC_BLOCKS-1:0] protect_state;
  int                      error_cnt = 0;
  int                      n_checks = 0;
  int                      cyc = 0;
  always #50 clk = ~clk;
  always @(posedge clk) cyc++;
  ofpc_cpu_model cpu_u (.clk(clk), .rsp(rsp), .req(req));
  ofpc_ctrl #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC), .SMALL_PAGE(1'b0)) dut_u (
    .clk(clk), .rst(rst), .req(req), .read_protect(read_protect),
    .ext_tool_read(ext_tool_read), .strap_port_bit_zero(strap_port_bit_zero), .rsp(rsp),
    .busy(busy), .single_chip(single_chip), .fetch_base(fetch_base),
    .protect_state(protect_state));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic cmp_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp_bit
  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic do_reset(input logic s);
    rst = 1'b1;
    strap_port_bit_zero = s;
    tick(4);
    rst = 1'b0;
    tick(4);
  endtask : do_reset
  task automatic send(input ofpc_pkg::ofpc_cmd_t c, input logic [16:0] a, input logic [31:0] d);
    cpu_u.send(c, a, d, got);
  endtask : send
  // t0 is the cycle count of the edge that took the command; busy must
  // drop within two cycles of the expected operation length
  task automatic wait_idle(input int t0, input int exp);
    int k;
    for (k = 0; k < 2000 && busy === 1'b1; k++) tick(1);
    if (k == 2000) begin
      error_cnt++;
      stop_test();
    end else begin
      cmp(32'(cyc - t0 + 2 >= exp && cyc - t0 <= exp + 2), 32'h1);
    end
  endtask : wait_idle
  task automatic t_mode();
    do_reset(1'b0);
    cmp_bit(single_chip, 1'b0);
    cmp(fetch_base, `OFPC_ROM_BASE);
    do_reset(1'b1);
    strap_port_bit_zero = 1'b0;
    tick(4);
    cmp_bit(single_chip, 1'b1);
    cmp(fetch_base, `OFPC_FLASH_BASE);
  endtask : t_mode
  task automatic t_prog();
    logic tog;
    int   t0;
    send(ofpc_pkg::OFPC_CMD_BLK_ERASE, 17'h00400, 32'h0);
    wait_idle(cyc - 1, ERASE_CYC);
    send(ofpc_pkg::OFPC_CMD_READ, 17'h0047F, 32'h0);
    cmp(got.rdata, `OFPC_ERASED);
    send(ofpc_pkg::OFPC_CMD_LOAD, 17'h00400, 32'hA5A50F0F);
    send(ofpc_pkg::OFPC_CMD_LOAD, 17'h0047F, 32'h12345678);
    send(ofpc_pkg::OFPC_CMD_PROG, 17'h00400, 32'h0);
    t0 = cyc - 1;
    cmp_bit(busy, 1'b1);
    send(ofpc_pkg::OFPC_CMD_READ, 17'h00400, 32'h0);
    cmp_bit(got.is_status, 1'b1);
    tog = got.rdata[`OFPC_TOGGLE_BIT];
    send(ofpc_pkg::OFPC_CMD_READ, 17'h00400, 32'h0);
    cmp_bit(got.rdata[`OFPC_TOGGLE_BIT], ~tog);
    wait_idle(t0, PROG_CYC);
    send(ofpc_pkg::OFPC_CMD_READ, 17'h0047F, 32'h0);
    cmp(got.rdata, 32'h12345678);
  endtask : t_prog
  task automatic t_protect();
    send(ofpc_pkg::OFPC_CMD_PROTECT, 17'h00400, 32'h0);
    cmp(32'(protect_state), 32'h2);
    send(ofpc_pkg::OFPC_CMD_PROG, 17'h00400, 32'h0);
    cmp_bit(busy, 1'b0);
    send(ofpc_pkg::OFPC_CMD_CHIP_ERASE, 17'h00000, 32'h0);
    cmp_bit(busy, 1'b0);
    send(ofpc_pkg::OFPC_CMD_BLK_ERASE, 17'h00000, 32'h0);
    cmp_bit(busy, 1'b1);
    wait_idle(cyc - 1, ERASE_CYC);
    read_protect = 1'b1;
    ext_tool_read = 1'b1;
    send(ofpc_pkg::OFPC_CMD_READ, 17'h00400, 32'h0);
    cmp(got.rdata, 32'h0);
    ext_tool_read = 1'b0;
    send(ofpc_pkg::OFPC_CMD_READ, 17'h00400, 32'h0);
    cmp(got.rdata, 32'hA5A50F0F);
    send(ofpc_pkg::OFPC_CMD_UNPROTECT, 17'h00000, 32'h0);
    cmp(32'(protect_state), 32'h0);
  endtask : t_protect
  initial begin
    t_mode();
    t_prog();
    t_protect();
    stop_test();
  end
endmodule : tb_onchip_flash_program_control
bind ofpc_ctrl ofpc_ctrl_asserts #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) chk_u (
  .clk(clk), .rst(rst), .req(req), .read_protect(read_protect),
  .ext_tool_read(ext_tool_read), .strap_port_bit_zero(strap_port_bit_zero), .rsp(rsp),
  .busy(busy), .single_chip(single_chip), .fetch_base(fetch_base),
  .protect_state(protect_state));
